// *** design/cold_load_pkg.sv ***
package cold_load_pkg;
  localparam int TICK_WIDTH  = 16;
  localparam int CUR_WIDTH   = 16;
  localparam logic [1:0] MODE_BREAKER = 2'h0;
  localparam logic [1:0] MODE_UNDER   = 2'h1;
  localparam logic [1:0] MODE_AND     = 2'h2;
  localparam logic [1:0] MODE_OR      = 2'h3;
  localparam logic [1:0] BLOCK_EXT    = 2'h1;
  localparam logic [1:0] BLOCK_INT    = 2'h2;
  localparam logic [TICK_WIDTH-1:0] TICKS_ZERO = 16'h0000;
  // Drop-off ratio 9/10 of the inrush threshold
  localparam int DROP_NUM = 9;
  localparam int DROP_DEN = 10;
  typedef enum logic [2:0] {
    ST_WARM    = 3'b000,
    ST_LOADOFF = 3'b001,
    ST_COLD    = 3'b010,
    ST_INRUSH  = 3'b011,
    ST_SETTLE  = 3'b100
  } state_type;
endpackage : cold_load_pkg

// *** design/tick_timer.sv ***
`timescale 1ns/1ps
module tick_timer
  import cold_load_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  enable_in,
  input  wire logic                  run_in,
  input  wire logic                  tick_in,
  input  wire logic [TICK_WIDTH-1:0] limit_in,
  output logic                       done_out
);
  import cold_load_pkg::*;
  logic [TICK_WIDTH-1:0] count;
  logic [TICK_WIDTH-1:0] next_count;
  logic                  next_done;

  // Restarts from zero whenever run drops
  always_comb begin
    next_count = count;
    next_done  = done_out;
    if (!run_in) begin
      next_count = TICKS_ZERO;
      next_done  = 1'b0;
    end else if (count >= limit_in) begin
      next_done = 1'b1;
    end else if (tick_in) begin
      next_count = count + 16'h0001;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count    <= TICKS_ZERO;
      done_out <= 1'b0;
    end else if (enable_in) begin
      count    <= next_count;
      done_out <= next_done;
    end
  end
endmodule : tick_timer

// *** design/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic enable_in,
  input  wire logic pin_in,
  output logic      level_out
);
  logic stage1;
  logic stage2;
  logic stage3;
  logic next_level;

  // Change accepted once the last two stages agree
  always_comb begin
    next_level = level_out;
    if (stage2 == stage3) begin
      next_level = stage3;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      stage1    <= 1'b0;
      stage2    <= 1'b0;
      stage3    <= 1'b0;
      level_out <= 1'b0;
    end else if (enable_in) begin
      stage1    <= pin_in;
      stage2    <= stage1;
      stage3    <= stage2;
      level_out <= next_level;
    end
  end
endmodule : pin_sync

// *** design/cold_load_supervisor.sv ***
`timescale 1ns/1ps
module cold_load_supervisor
  import cold_load_pkg::*;
(
  input  wire logic                  CLK_IN,
  input  wire logic                  RESET_IN,
  input  wire logic                  CLK_EN_IN,
  input  wire logic                  TICK_IN,
  input  wire logic [1:0]            DETECT_MODE_IN,
  input  wire logic                  BREAKER_OPEN_IN,
  input  wire logic                  UNDERCURRENT_IN,
  input  wire logic [CUR_WIDTH-1:0]  LOAD_CURRENT_IN,
  input  wire logic [CUR_WIDTH-1:0]  INRUSH_THRESHOLD_IN,
  input  wire logic                  AUTO_RECLOSE_RUNNING_IN,
  input  wire logic [1:0]            BLOCK_SELECT_IN,
  input  wire logic                  EXT_BLOCK_IN,
  input  wire logic                  INT_BLOCK_IN,
  input  wire logic [TICK_WIDTH-1:0] LOAD_OFF_TICKS_IN,
  input  wire logic [TICK_WIDTH-1:0] SETTLE_TICKS_IN,
  input  wire logic [TICK_WIDTH-1:0] MAX_BLOCK_TICKS_IN,
  output logic                       COLD_LOAD_ACTIVE_FLAG_OUT,
  output logic                       COLD_DETECTED_OUT,
  output logic                       INRUSH_OUT,
  output logic                       BLOCKED_OUT
);
  import cold_load_pkg::*;

  // Drop level as integer math, no divider
  function automatic logic above_drop(input logic [CUR_WIDTH-1:0] cur,
                                      input logic [CUR_WIDTH-1:0] thr);
    logic [CUR_WIDTH+3:0] lhs;
    logic [CUR_WIDTH+3:0] rhs;
    lhs = 20'(cur) * 20'(DROP_DEN);
    rhs = 20'(thr) * 20'(DROP_NUM);
    return lhs > rhs;
  endfunction : above_drop

  logic breaker_open_sync;
  logic ext_block_sync;

  pin_sync u_sync_breaker (
    .clk_in    (CLK_IN),
    .reset_in  (RESET_IN),
    .enable_in (CLK_EN_IN),
    .pin_in    (BREAKER_OPEN_IN),
    .level_out (breaker_open_sync)
  );

  pin_sync u_sync_block (
    .clk_in    (CLK_IN),
    .reset_in  (RESET_IN),
    .enable_in (CLK_EN_IN),
    .pin_in    (EXT_BLOCK_IN),
    .level_out (ext_block_sync)
  );

  state_type state;
  state_type next_state;
  logic      cold;
  logic      blocked;
  logic      over_thr;
  logic      over_drop;
  logic      loadoff_done;
  logic      settle_done;
  logic      maxblk_done;
  logic      maxblk_run;
  logic      next_maxblk_run;
  logic      next_flag;
  logic      next_inrush;

  // Undercurrent comparator is same-clock logic, used directly
  always_comb begin
    unique case (DETECT_MODE_IN)
      MODE_BREAKER: cold = breaker_open_sync;
      MODE_UNDER:   cold = UNDERCURRENT_IN;
      MODE_AND:     cold = breaker_open_sync & UNDERCURRENT_IN;
      MODE_OR:      cold = breaker_open_sync | UNDERCURRENT_IN;
    endcase
  end

  assign blocked = ((BLOCK_SELECT_IN & BLOCK_EXT) != 2'h0 && ext_block_sync)
                 | ((BLOCK_SELECT_IN & BLOCK_INT) != 2'h0 && INT_BLOCK_IN)
                 | AUTO_RECLOSE_RUNNING_IN;
  assign over_thr  = LOAD_CURRENT_IN > INRUSH_THRESHOLD_IN;
  assign over_drop = above_drop(LOAD_CURRENT_IN, INRUSH_THRESHOLD_IN);

  tick_timer u_loadoff (
    .clk_in    (CLK_IN),
    .reset_in  (RESET_IN),
    .enable_in (CLK_EN_IN),
    .run_in    (state == ST_LOADOFF),
    .tick_in   (TICK_IN),
    .limit_in  (LOAD_OFF_TICKS_IN),
    .done_out  (loadoff_done)
  );

  // Settle restarts whenever current climbs back above the drop level
  tick_timer u_settle (
    .clk_in    (CLK_IN),
    .reset_in  (RESET_IN),
    .enable_in (CLK_EN_IN),
    .run_in    (state == ST_SETTLE && !over_drop),
    .tick_in   (TICK_IN),
    .limit_in  (SETTLE_TICKS_IN),
    .done_out  (settle_done)
  );

  tick_timer u_maxblk (
    .clk_in    (CLK_IN),
    .reset_in  (RESET_IN),
    .enable_in (CLK_EN_IN),
    .run_in    (maxblk_run),
    .tick_in   (TICK_IN),
    .limit_in  (MAX_BLOCK_TICKS_IN),
    .done_out  (maxblk_done)
  );

  always_comb begin
    next_state      = state;
    next_maxblk_run = maxblk_run;
    if (blocked) begin
      next_state      = ST_WARM;
      next_maxblk_run = 1'b0;
    end else begin
      unique case (state)
        ST_WARM: begin
          if (cold) begin
            next_state = ST_LOADOFF;
          end
        end
        ST_LOADOFF: begin
          if (!cold) begin
            next_state = ST_WARM;
          end else if (loadoff_done) begin
            next_state = ST_COLD;
          end
        end
        ST_COLD: begin
          if (!cold) begin
            next_state      = ST_INRUSH;
            next_maxblk_run = 1'b1;
          end
        end
        ST_INRUSH: begin
          if (cold) begin
            next_state      = ST_LOADOFF;
            next_maxblk_run = 1'b0;
          end else if (maxblk_done) begin
            next_state      = ST_WARM;
            next_maxblk_run = 1'b0;
          end else if (INRUSH_OUT && !over_drop) begin
            next_state = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (cold) begin
            next_state      = ST_LOADOFF;
            next_maxblk_run = 1'b0;
          end else if (settle_done || maxblk_done) begin
            next_state      = ST_WARM;
            next_maxblk_run = 1'b0;
          end
        end
        default: begin
          next_state      = ST_WARM;
          next_maxblk_run = 1'b0;
        end
      endcase
    end
  end

  // Inrush seen latch, cleared on leaving the detector states
  always_comb begin
    next_inrush = INRUSH_OUT;
    if (next_state != ST_INRUSH && next_state != ST_SETTLE) begin
      next_inrush = 1'b0;
    end else if (over_thr) begin
      next_inrush = 1'b1;
    end
    // Only a flag leaves this block, never a trip
    next_flag = (next_state == ST_COLD || next_state == ST_INRUSH
              || next_state == ST_SETTLE);
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state                     <= ST_WARM;
      maxblk_run                <= 1'b0;
      COLD_LOAD_ACTIVE_FLAG_OUT <= 1'b0;
      COLD_DETECTED_OUT         <= 1'b0;
      INRUSH_OUT                <= 1'b0;
      BLOCKED_OUT               <= 1'b0;
    end else if (CLK_EN_IN) begin
      state                     <= next_state;
      maxblk_run                <= next_maxblk_run;
      COLD_LOAD_ACTIVE_FLAG_OUT <= next_flag;
      COLD_DETECTED_OUT         <= cold;
      INRUSH_OUT                <= next_inrush;
      BLOCKED_OUT               <= blocked;
    end
  end
endmodule : cold_load_supervisor

// *** tb/cold_load_sva.sv ***
`timescale 1ns/1ps
module cold_load_sva
  import cold_load_pkg::*;
(
  input wire logic                  CLK_IN,
  input wire logic                  RESET_IN,
  input wire logic                  TICK_IN,
  input wire logic [1:0]            DETECT_MODE_IN,
  input wire logic                  BREAKER_OPEN_IN,
  input wire logic [CUR_WIDTH-1:0]  LOAD_CURRENT_IN,
  input wire logic [CUR_WIDTH-1:0]  INRUSH_THRESHOLD_IN,
  input wire logic                  AUTO_RECLOSE_RUNNING_IN,
  input wire logic [1:0]            BLOCK_SELECT_IN,
  input wire logic                  INT_BLOCK_IN,
  input wire logic [TICK_WIDTH-1:0] MAX_BLOCK_TICKS_IN,
  input wire logic                  COLD_LOAD_ACTIVE_FLAG_OUT,
  input wire logic                  COLD_DETECTED_OUT,
  input wire logic                  INRUSH_OUT,
  input wire logic                  BLOCKED_OUT
);
  import cold_load_pkg::*;
  logic        f;
  logic        over;
  logic [16:0] ticks;
  assign f    = COLD_LOAD_ACTIVE_FLAG_OUT;
  assign over = LOAD_CURRENT_IN > INRUSH_THRESHOLD_IN;
  // Ticks since cold ended; two spare ticks cover the done pipeline
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN)
      ticks <= '0;
    else if (COLD_DETECTED_OUT)
      ticks <= '0;
    else if (TICK_IN)
      ticks <= ticks + 17'h1;
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  a_hold_low: assert property (BLOCKED_OUT [*3] |-> !f)
    else $error("flag high while blocked");
  a_reclose_block:
    assert property (AUTO_RECLOSE_RUNNING_IN |-> ##[1:2] BLOCKED_OUT)
    else $error("reclose did not block");
  a_int_block:
    assert property (INT_BLOCK_IN && BLOCK_SELECT_IN[1] |-> ##[1:2] BLOCKED_OUT)
    else $error("internal block ignored");
  a_rise_cold: assert property ($rose(f) |-> $past(COLD_DETECTED_OUT))
    else $error("flag rose without cold");
  a_rise_free: assert property ($rose(f) |-> !BLOCKED_OUT)
    else $error("flag rose while blocked");
  a_inrush_seen: assert property ($rose(INRUSH_OUT) |-> $past(over))
    else $error("inrush without overcurrent");
  a_max_window:
    assert property (f && !COLD_DETECTED_OUT |->
      ticks <= MAX_BLOCK_TICKS_IN + 17'h2)
    else $error("flag beyond max block");
  a_warm_breaker:
    assert property ((DETECT_MODE_IN == MODE_BREAKER && !BREAKER_OPEN_IN) [*6]
      |-> !COLD_DETECTED_OUT) else $error("cold with breaker closed");
  c_flag_up: cover property ($rose(f));
  c_inrush: cover property ($rose(INRUSH_OUT));
  c_release: cover property ($fell(f) && !BLOCKED_OUT);
endmodule : cold_load_sva
bind cold_load_supervisor cold_load_sva cold_load_sva_inst (.*);

// *** tb/load_side_model.sv ***
`timescale 1ns/1ps
module load_side_model
  import cold_load_pkg::*;
#(parameter logic [CUR_WIDTH-1:0] UC_LEVEL = 16'h000a)
(
  input  wire logic                 open_cmd_in,
  input  wire logic [CUR_WIDTH-1:0] amps_cmd_in,
  output logic                      breaker_open_out,
  output logic                      undercurrent_out,
  output logic [CUR_WIDTH-1:0]      current_out
);
  // Breaker indicator and the same breaker's current transformers
  assign breaker_open_out = open_cmd_in;
  assign current_out      = amps_cmd_in;
  assign undercurrent_out = amps_cmd_in < UC_LEVEL;
endmodule : load_side_model

// *** tb/cold_load_supervisor_tb.sv ***
`timescale 1ns/1ps
module cold_load_supervisor_tb;
  import cold_load_pkg::*;
  logic                 clk, rst, tick, opn, ar, ext, intb, en;
  logic                 flag, cold, inr, blk, br, uc;
  logic [1:0]           mode, bsel;
  logic [1:0]           div = 2'h0;
  logic [CUR_WIDTH-1:0] amps, cur;
  int                   error_cnt = 0;
  int                   num_checks = 0;
  load_side_model load_side_model_inst (.open_cmd_in(opn),
    .amps_cmd_in(amps), .breaker_open_out(br), .undercurrent_out(uc),
    .current_out(cur));
  cold_load_supervisor cold_load_supervisor_inst (.CLK_IN(clk),
    .RESET_IN(rst), .CLK_EN_IN(en), .TICK_IN(tick),
    .DETECT_MODE_IN(mode), .BREAKER_OPEN_IN(br), .UNDERCURRENT_IN(uc),
    .LOAD_CURRENT_IN(cur), .INRUSH_THRESHOLD_IN(16'h0064),
    .AUTO_RECLOSE_RUNNING_IN(ar), .BLOCK_SELECT_IN(bsel),
    .EXT_BLOCK_IN(ext), .INT_BLOCK_IN(intb),
    .LOAD_OFF_TICKS_IN(16'h0003), .SETTLE_TICKS_IN(16'h0002),
    .MAX_BLOCK_TICKS_IN(16'h0014), .COLD_LOAD_ACTIVE_FLAG_OUT(flag),
    .COLD_DETECTED_OUT(cold), .INRUSH_OUT(inr), .BLOCKED_OUT(blk));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // One tick every four clocks keeps timer runs short
  always @(posedge clk) begin
    div  <= div + 2'h1;
    tick <= (div == 2'h3);
  end
  task automatic check(input string what, input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wait_flag(input logic v, input int lim);
    for (int i = 0; i < lim && flag !== v; i++)
      @(negedge clk);
    check("flag wait", flag, v);
    if (flag !== v)
      wrap_up();
  endtask : wait_flag
  task automatic drive(input logic o, input logic [CUR_WIDTH-1:0] a);
    @(posedge clk);
    opn  <= o;
    amps <= a;
  endtask : drive
  initial begin
    {rst, opn, ar, ext, intb, en} = 6'h21;
    mode = MODE_OR;
    bsel = 2'h3;
    amps = 16'h00c8;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        mode <= 2'(m);
        drive(k == 0, (k == 0) ? 16'h00c8 : 16'h0000);
        cyc(8);
        check("cold", cold, m == 0 ? k == 0 : m == 1 ? k == 1 : m == 3);
        drive(1'b0, 16'h00c8);
        cyc(8);
      end
    end
    @(posedge clk);
    mode <= MODE_OR;
    drive(1'b1, 16'h00c8);
    cyc(8);
    check("early flag", flag, 1'b0);
    wait_flag(1'b1, 40);
    // Enable low: breaker closing must not be seen while frozen
    @(posedge clk);
    en  <= 1'b0;
    opn <= 1'b0;
    cyc(12);
    check("frozen flag", flag, 1'b1);
    check("frozen cold", cold, 1'b1);
    check("frozen inrush", inr, 1'b0);
    @(posedge clk);
    opn <= 1'b1;
    en  <= 1'b1;
    drive(1'b0, 16'h00c8);
    cyc(8);
    check("inrush", inr, 1'b1);
    check("held", flag, 1'b1);
    drive(1'b0, 16'h005b);
    cyc(30);
    check("above drop", flag, 1'b1);
    drive(1'b0, 16'h005a);
    cyc(3);
    check("settling", flag, 1'b1);
    // Climbing back above the drop level restarts the settle time
    drive(1'b0, 16'h005b);
    cyc(12);
    check("settle restart", flag, 1'b1);
    drive(1'b0, 16'h005a);
    wait_flag(1'b0, 20);
    drive(1'b1, 16'h00c8);
    wait_flag(1'b1, 60);
    drive(1'b0, 16'h00c8);
    cyc(60);
    check("max hold", flag, 1'b1);
    wait_flag(1'b0, 40);
    for (int s = 0; s < 3; s++) begin
      drive(1'b1, 16'h00c8);
      wait_flag(1'b1, 60);
      @(posedge clk);
      ar   <= (s == 0);
      ext  <= (s == 1);
      intb <= (s == 2);
      cyc(10);
      check("blocked flag", flag, 1'b0);
      check("block seen", blk, 1'b1);
      @(posedge clk);
      {ar, ext, intb} <= 3'h0;
      drive(1'b0, 16'h00c8);
      cyc(8);
    end
    @(posedge clk);
    bsel <= BLOCK_INT;
    ext  <= 1'b1;
    drive(1'b1, 16'h00c8);
    wait_flag(1'b1, 60);
    wrap_up();
  end
endmodule : cold_load_supervisor_tb
